// file: core/acl_table_access.sv
// Indirect access engine for the per-port 16-entry, 14-byte rule table
//
// Summary of operation
// - Per-port 16-bit rule cascade membership mask
// - Per-port 14-bit byte select mask
// - Select bit 0 maps byte 0x0D, reversed
// - Store-done flag at bit 6, resets one
// - Fetch-done flag at bit 5, resets one
// - Direction zero with index starts a fetch
// - Direction one with index starts a store
// - Store copies selected holding buffer bytes
// - Ring option picks single-entry miss or cascade hit
// - Table code 010 and port code select
// - Offset register then data register moves byte
// - Control bit 4 picks read or write
// - Port codes 1, 2, 3 and 5
// - Entry bytes read at offsets 0x00..0x0D
// - Select mask split at 0x10 and 0x11
// - Cascade mask high byte at offset 0x0C
`timescale 1ns/1ps
module acl_table_access #(
    parameter int PORTS   = 4,  // Number of switch ports
    parameter int ENTRIES = 16, // Rule entries per port
    parameter int EBYTES  = 14  // Bytes per entry
) (
    input  wire logic                   CLK_IN,
    input  wire logic                   NRST_IN,
    input  wire acl_pkg::acl_host_req_t HOST_REQ_IN,
    output logic [7:0]                  REG_RDATA_OUT,
    input  wire acl_pkg::acl_ring_t     RING_IN,
    output logic                        RING_HIT_OUT,
    output logic [PORTS*16-1:0]         RULE_CASCADE_MASK_OUT,
    output logic                        BUSY_OUT
);
    // ==================================================================
    // State
    logic [7:0]  ind_ctrl;                        // Table and port select
    logic [7:0]  ind_addr;                        // Per-port offset
    logic [7:0]  hold      [PORTS][EBYTES];        // Holding buffers
    logic [7:0]  table_mem [PORTS][ENTRIES][EBYTES];
    logic [13:0] entry_byte_select [PORTS];        // Byte selects per port
    logic [3:0]  entry_index [PORTS];              // Entry index per port
    logic        req_dir [PORTS];                  // Last request direction
    logic        ring_single_entry_option [PORTS];
    logic        store_done;                       // Shared engine flags
    logic        fetch_done;
    acl_pkg::acl_state_t state;
    logic [3:0]  cnt;                              // Byte being moved
    logic [1:0]  xport;                            // Port being served
    logic [7:0]  rdata;
    logic        ring_hit;

    logic [7:0]  next_ind_ctrl;
    logic [7:0]  next_ind_addr;
    logic [7:0]  next_hold      [PORTS][EBYTES];
    logic [7:0]  next_table_mem [PORTS][ENTRIES][EBYTES];
    logic [13:0] next_entry_byte_select [PORTS];
    logic [3:0]  next_entry_index [PORTS];
    logic        next_req_dir [PORTS];
    logic        next_ring_single_entry_option [PORTS];
    logic        next_store_done;
    logic        next_fetch_done;
    acl_pkg::acl_state_t next_state;
    logic [3:0]  next_cnt;
    logic [1:0]  next_xport;
    logic [7:0]  next_rdata;
    logic        next_ring_hit;

    // ==================================================================
    // Decode of the indirect select
    logic        sel_ok;      // List table and a known port
    logic [1:0]  sel_port;    // Decoded port index
    logic        fetch_go;    // Fetch triggered this cycle
    logic        store_go;    // Store triggered this cycle
    logic [15:0] casc_ring;   // Cascade mask of the ring frame's port

    // Port code to index; unknown codes leave the access with no target
    always_comb begin
        sel_port = 2'h0;
        sel_ok   = (ind_ctrl[7:5] == acl_pkg::TABLE_SEL_LIST);
        case (ind_ctrl[3:0])
            acl_pkg::PORT_CODE_0: sel_port = 2'h0;
            acl_pkg::PORT_CODE_1: sel_port = 2'h1;
            acl_pkg::PORT_CODE_2: sel_port = 2'h2;
            acl_pkg::PORT_CODE_3: sel_port = 2'h3;
            default: sel_ok = 1'b0;
        endcase
    end

    // ==================================================================
    // Next-state logic for registers, buffers and the transfer engine
    always_comb begin
        next_ind_ctrl   = ind_ctrl;
        next_ind_addr   = ind_addr;
        next_hold       = hold;
        next_table_mem  = table_mem;
        next_entry_byte_select = entry_byte_select;
        next_entry_index       = entry_index;
        next_req_dir           = req_dir;
        next_ring_single_entry_option = ring_single_entry_option;
        next_store_done = store_done;
        next_fetch_done = fetch_done;
        next_state      = state;
        next_cnt        = cnt;
        next_xport      = xport;
        next_rdata      = rdata;
        fetch_go        = 1'b0;
        store_go        = 1'b0;

        // Transfer engine moves one byte per clock; the host write below
        // is applied afterwards so it wins on a shared holding byte
        if (state != acl_pkg::ST_IDLE) begin
            if (entry_byte_select[xport][acl_pkg::LAST_BYTE_IDX - cnt]) begin
                if (state == acl_pkg::ST_FETCH) begin
                    next_hold[xport][cnt] = table_mem[xport][entry_index[xport]][cnt];
                end else begin
                    next_table_mem[xport][entry_index[xport]][cnt] = hold[xport][cnt];
                end
            end
            next_cnt = cnt + 4'h1;
            if (cnt == acl_pkg::LAST_BYTE_IDX) begin
                // End of entry: raise the flag of the finished kind
                next_state = acl_pkg::ST_IDLE;
                next_cnt   = 4'h0;
                if (state == acl_pkg::ST_FETCH) begin
                    next_fetch_done = 1'b1;
                end else begin
                    next_store_done = 1'b1;
                end
            end
        end

        // Host writes
        if (HOST_REQ_IN.wr) begin
            case (HOST_REQ_IN.addr)
                acl_pkg::ADDR_IND_CTRL: next_ind_ctrl = HOST_REQ_IN.wdata;
                acl_pkg::ADDR_IND_ADDR: next_ind_addr = HOST_REQ_IN.wdata;
                acl_pkg::ADDR_IND_DATA: begin
                    // Bit 4 low means a write to the per-port register
                    if (sel_ok && !ind_ctrl[acl_pkg::CTRL_DIR_BIT]) begin
                        if (ind_addr <= acl_pkg::OFF_LAST_BYTE) begin
                            next_hold[sel_port][ind_addr[3:0]] = HOST_REQ_IN.wdata;
                        end else if (ind_addr == acl_pkg::OFF_BSEL_HI) begin
                            next_entry_byte_select[sel_port][13:8] =
                                HOST_REQ_IN.wdata[5:0];
                        end else if (ind_addr == acl_pkg::OFF_BSEL_LO) begin
                            next_entry_byte_select[sel_port][7:0] = HOST_REQ_IN.wdata;
                        end else if (ind_addr == acl_pkg::OFF_CTRL_ONE) begin
                            // A trigger while busy is dropped whole: the engine
                            // is shared, so a second port cannot steal it
                            if (state == acl_pkg::ST_IDLE) begin
                                next_req_dir[sel_port] =
                                    HOST_REQ_IN.wdata[acl_pkg::REQ_DIR_BIT];
                                next_entry_index[sel_port] = HOST_REQ_IN.wdata[3:0];
                                next_xport = sel_port;
                                next_cnt   = 4'h0;
                                if (HOST_REQ_IN.wdata[acl_pkg::REQ_DIR_BIT]) begin
                                    store_go        = 1'b1;
                                    next_state      = acl_pkg::ST_STORE;
                                    next_store_done = 1'b0;
                                end else begin
                                    fetch_go        = 1'b1;
                                    next_state      = acl_pkg::ST_FETCH;
                                    next_fetch_done = 1'b0;
                                end
                            end
                        end else if (ind_addr == acl_pkg::OFF_CTRL_TWO) begin
                            next_ring_single_entry_option[sel_port] =
                                HOST_REQ_IN.wdata[acl_pkg::RING_OPT_BIT];
                        end
                    end
                end
                default: ;
            endcase
        end

        // Host reads: answer registered one clock after the strobe
        if (HOST_REQ_IN.rd) begin
            next_rdata = acl_pkg::RST_BYTE;
            case (HOST_REQ_IN.addr)
                acl_pkg::ADDR_IND_CTRL: next_rdata = ind_ctrl;
                acl_pkg::ADDR_IND_ADDR: next_rdata = ind_addr;
                acl_pkg::ADDR_IND_DATA: begin
                    if (sel_ok) begin
                        if (ind_addr <= acl_pkg::OFF_LAST_BYTE) begin
                            next_rdata = hold[sel_port][ind_addr[3:0]];
                        end else if (ind_addr == acl_pkg::OFF_BSEL_HI) begin
                            next_rdata = {2'h0, entry_byte_select[sel_port][13:8]};
                        end else if (ind_addr == acl_pkg::OFF_BSEL_LO) begin
                            next_rdata = entry_byte_select[sel_port][7:0];
                        end else if (ind_addr == acl_pkg::OFF_CTRL_ONE) begin
                            next_rdata = {1'b0, store_done, fetch_done,
                                          req_dir[sel_port], entry_index[sel_port]};
                        end else if (ind_addr == acl_pkg::OFF_CTRL_TWO) begin
                            next_rdata = {7'h00, ring_single_entry_option[sel_port]};
                        end
                    end
                end
                default: ;
            endcase
        end
    end

    // ==================================================================
    // Ring frame classification
    always_comb begin
        casc_ring = {hold[RING_IN.port][acl_pkg::OFF_CASC_HI[3:0]],
                     hold[RING_IN.port][acl_pkg::OFF_CASC_LO[3:0]]};
        next_ring_hit = 1'b0;
        if (RING_IN.frame) begin
            // Single-entry mode turns a match into a miss; cascade mode
            // needs every member of the rule set to match
            if (!ring_single_entry_option[RING_IN.port]) begin
                next_ring_hit = (casc_ring != 16'h0000) &&
                                ((RING_IN.match & casc_ring) == casc_ring);
            end
        end
    end

    // ==================================================================
    // Registers
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            ind_ctrl   <= acl_pkg::RST_BYTE;
            ind_addr   <= acl_pkg::RST_BYTE;
            hold       <= '{default: '{default: acl_pkg::RST_BYTE}};
            table_mem  <= '{default: '{default: '{default: acl_pkg::RST_BYTE}}};
            entry_byte_select <= '{default: 14'h0000};
            entry_index       <= '{default: 4'h0};
            req_dir           <= '{default: 1'b0};
            ring_single_entry_option <= '{default: 1'b0};
            store_done <= acl_pkg::RST_DONE;
            fetch_done <= acl_pkg::RST_DONE;
            state      <= acl_pkg::ST_IDLE;
            cnt        <= 4'h0;
            xport      <= 2'h0;
            rdata      <= acl_pkg::RST_BYTE;
            ring_hit   <= 1'b0;
        end else begin
            ind_ctrl   <= next_ind_ctrl;
            ind_addr   <= next_ind_addr;
            hold       <= next_hold;
            table_mem  <= next_table_mem;
            entry_byte_select <= next_entry_byte_select;
            entry_index       <= next_entry_index;
            req_dir           <= next_req_dir;
            ring_single_entry_option <= next_ring_single_entry_option;
            store_done <= next_store_done;
            fetch_done <= next_fetch_done;
            state      <= next_state;
            cnt        <= next_cnt;
            xport      <= next_xport;
            rdata      <= next_rdata;
            ring_hit   <= next_ring_hit;
        end
    end

    // ==================================================================
    // Outputs
    assign REG_RDATA_OUT = rdata;
    assign RING_HIT_OUT  = ring_hit;
    assign BUSY_OUT      = (state != acl_pkg::ST_IDLE);

    // Cascade mask of each port, from its holding bytes 0x0C and 0x0D
    for (genvar p = 0; p < PORTS; p++) begin : g_casc
        assign RULE_CASCADE_MASK_OUT[p*16 +: 16] =
            {hold[p][acl_pkg::OFF_CASC_HI[3:0]], hold[p][acl_pkg::OFF_CASC_LO[3:0]]};
    end

    // ==================================================================
    // Checks
    sequence s_fetch_runs;
        !fetch_done [*8] ##1 !fetch_done [*6];
    endsequence

    sequence s_store_runs;
        !store_done [*8] ##1 !store_done [*6];
    endsequence

    // Flag drops at the trigger and stays low for all 14 byte moves
    chk_fetch_flag_cycle: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        fetch_go |=> s_fetch_runs ##1 fetch_done)
        else $error("fetch flag timing wrong");

    chk_store_flag_cycle: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        store_go |=> s_store_runs ##1 store_done)
        else $error("store flag timing wrong");

    chk_idle_flags_set: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (state == acl_pkg::ST_IDLE) |-> (fetch_done && store_done))
        else $error("flag low while idle");

    // Engine writes each selected table byte during a store and leaves unselected bytes unchanged
    chk_store_byte_copy: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (state == acl_pkg::ST_STORE) &&
        entry_byte_select[xport][acl_pkg::LAST_BYTE_IDX - cnt] |=>
        table_mem[$past(xport)][$past(entry_index[xport])][$past(cnt)] ==
        $past(hold[xport][cnt]))
        else $error("selected byte not stored");

    chk_store_byte_skip: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        (state == acl_pkg::ST_STORE) &&
        !entry_byte_select[xport][acl_pkg::LAST_BYTE_IDX - cnt] |=>
        table_mem[$past(xport)][$past(entry_index[xport])][$past(cnt)] ==
        $past(table_mem[xport][entry_index[xport]][cnt]))
        else $error("unselected byte changed");

    // Unused top select bits must read zero
    chk_bsel_high_zero: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        HOST_REQ_IN.rd && HOST_REQ_IN.addr == acl_pkg::ADDR_IND_DATA &&
        ind_addr == acl_pkg::OFF_BSEL_HI |=> REG_RDATA_OUT[7:6] == 2'h0)
        else $error("unused select bits not zero");

    chk_status_read: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        HOST_REQ_IN.rd && HOST_REQ_IN.addr == acl_pkg::ADDR_IND_DATA && sel_ok &&
        ind_addr == acl_pkg::OFF_CTRL_ONE |=>
        REG_RDATA_OUT[6:5] == {$past(store_done), $past(fetch_done)})
        else $error("status bits misreported");

    // Ring checks follow the option bit of the frame's port
    chk_ring_single_miss: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        RING_IN.frame && ring_single_entry_option[RING_IN.port] |=> !RING_HIT_OUT)
        else $error("single-entry ring frame hit");

    chk_ring_cascade_hit: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        RING_IN.frame && !ring_single_entry_option[RING_IN.port] &&
        casc_ring != 16'h0000 && (RING_IN.match & casc_ring) == casc_ring
        |=> RING_HIT_OUT)
        else $error("cascade ring frame missed");

    // A trigger that meets a busy engine must leave its own port's entry index alone
    chk_busy_drops_req: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        HOST_REQ_IN.wr && HOST_REQ_IN.addr == acl_pkg::ADDR_IND_DATA && sel_ok &&
        !ind_ctrl[acl_pkg::CTRL_DIR_BIT] && ind_addr == acl_pkg::OFF_CTRL_ONE &&
        (state != acl_pkg::ST_IDLE) |=>
        entry_index[$past(sel_port)] == $past(entry_index[sel_port]))
        else $error("trigger taken while busy");

    // The engine is busy exactly while one completion flag is low
    chk_busy_flag_match: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        BUSY_OUT == !(fetch_done && store_done))
        else $error("busy and flags disagree");
endmodule : acl_table_access

// file: core/acl_pkg.sv
// Package for the per-port rule table indirect access engine
package acl_pkg;
    // ==================================================================
    // Top-level indirect access addresses
    localparam logic [7:0] ADDR_IND_CTRL  = 8'h6E; // Table and port select
    localparam logic [7:0] ADDR_IND_ADDR  = 8'h6F; // Per-port byte offset
    localparam logic [7:0] ADDR_IND_DATA  = 8'hA0; // Indirect byte data
    localparam logic [2:0] TABLE_SEL_LIST = 3'h2;  // Bits 7:5 code for the list table
    localparam int         CTRL_DIR_BIT   = 4;     // 1 = read, 0 = write of per-port regs

    // ==================================================================
    // Port codes in the low nibble
    localparam logic [3:0] PORT_CODE_0 = 4'h1;
    localparam logic [3:0] PORT_CODE_1 = 4'h2;
    localparam logic [3:0] PORT_CODE_2 = 4'h3;
    localparam logic [3:0] PORT_CODE_3 = 4'h5;

    // ==================================================================
    // Per-port offsets
    localparam logic [7:0] OFF_LAST_BYTE = 8'h0D; // Holding buffer spans 0x00..0x0D
    localparam logic [7:0] OFF_CASC_HI   = 8'h0C; // Cascade mask bits 15:8
    localparam logic [7:0] OFF_CASC_LO   = 8'h0D; // Cascade mask bits 7:0
    localparam logic [7:0] OFF_BSEL_HI   = 8'h10; // Byte select bits 13:8
    localparam logic [7:0] OFF_BSEL_LO   = 8'h11; // Byte select bits 7:0
    localparam logic [7:0] OFF_CTRL_ONE  = 8'h12; // Access control one
    localparam logic [7:0] OFF_CTRL_TWO  = 8'h13; // Access control two

    // ==================================================================
    // Field positions and reset values
    localparam int         STORE_DONE_BIT = 6;
    localparam int         FETCH_DONE_BIT = 5;
    localparam int         REQ_DIR_BIT    = 4;
    localparam int         RING_OPT_BIT   = 0;
    localparam logic [3:0] LAST_BYTE_IDX  = 4'hD;  // Byte counter end value
    localparam logic [7:0] RST_BYTE       = 8'h00;
    localparam logic       RST_DONE       = 1'b1;

    // ==================================================================
    // Types
    typedef struct packed {
        logic       wr;    // Write strobe
        logic       rd;    // Read strobe
        logic [7:0] addr;  // Top-level register address
        logic [7:0] wdata; // Write data
    } acl_host_req_t;

    typedef struct packed {
        logic        frame; // Ring frame classified this cycle
        logic [1:0]  port;  // Ingress port index
        logic [15:0] match; // Entries matched by the frame
    } acl_ring_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_FETCH = 2'b01,
        ST_STORE = 2'b10
    } acl_state_t;
endpackage : acl_pkg

// file: verification/acl_host_model.sv
// Host manager model that reaches the rule table through the indirect registers
`timescale 1ns/1ps
module acl_host_model (
    input  wire logic                   clk_in,   // Bench clock
    input  wire logic [7:0]             rdata_in, // Read data from the device
    output acl_pkg::acl_host_req_t      req_out   // Strobed host request
);
    // ==================================================================
    // Bus cycles
    // Idle bus from time zero so no strobe is seen during reset
    initial req_out = '0;

    // One write strobe, raised after an edge and dropped at the sampling edge
    task automatic wr_top(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        req_out <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_in);
        req_out <= '0;
    endtask : wr_top

    // Read strobe; data is registered at the sampling edge, taken just after
    task automatic rd_top(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_in);
        req_out <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_in);
        req_out <= '0;
        #1;
        d = rdata_in;
    endtask : rd_top

    // ==================================================================
    // Per-port accesses: table and port select, then offset, then data
    task automatic wr_reg(input logic [3:0] code, input logic [7:0] off, input logic [7:0] d);
        wr_top(acl_pkg::ADDR_IND_CTRL, {acl_pkg::TABLE_SEL_LIST, 1'b0, code});
        wr_top(acl_pkg::ADDR_IND_ADDR, off);
        wr_top(acl_pkg::ADDR_IND_DATA, d);
    endtask : wr_reg

    // Read direction selected before the offset, as the device expects
    task automatic rd_reg(input logic [3:0] code, input logic [7:0] off, output logic [7:0] d);
        wr_top(acl_pkg::ADDR_IND_CTRL, {acl_pkg::TABLE_SEL_LIST, 1'b1, code});
        wr_top(acl_pkg::ADDR_IND_ADDR, off);
        rd_top(acl_pkg::ADDR_IND_DATA, d);
    endtask : rd_reg
endmodule : acl_host_model

// file: verification/tb.sv
// Self-checking bench for the rule table indirect access engine
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_fail++; \
    $display("MISMATCH t=%0t got %0h expected %0h", $time, (got), (exp)); end end
module tb;
    // ==================================================================
    // Signals and reference model state
    logic                   clk = 1'b0;       // 25 MHz bench clock
    logic                   nrst = 1'b0;      // Active-low reset
    acl_pkg::acl_ring_t     ring = '0;        // Ring frame stimulus
    acl_pkg::acl_host_req_t req;              // Host request from the model
    logic [7:0]             rdata;            // Register read data
    logic                   hit;              // Ring hit result
    logic                   busy;             // Transfer in progress
    logic [63:0]            casc;             // Cascade masks of all ports
    int                     n_fail = 0;       // Mismatch count
    int                     n_compared = 0;   // Comparison count
    logic [7:0]             seed = 8'h50;     // Pseudo-random state
    logic [7:0]             tbl [4][16][14];  // Expected table contents
    logic [7:0]             hold [4][14];     // Expected holding buffers
    logic [3:0]             codes [4] = '{acl_pkg::PORT_CODE_0, acl_pkg::PORT_CODE_1,
                                          acl_pkg::PORT_CODE_2, acl_pkg::PORT_CODE_3};
    logic [7:0]             rv;               // Scratch read value

    // Clock: invert every half period
    always #20 clk = ~clk;

    acl_table_access #(.PORTS(4), .ENTRIES(16), .EBYTES(14)) DUT (
        .CLK_IN(clk), .NRST_IN(nrst), .HOST_REQ_IN(req), .REG_RDATA_OUT(rdata),
        .RING_IN(ring), .RING_HIT_OUT(hit), .RULE_CASCADE_MASK_OUT(casc), .BUSY_OUT(busy));
    acl_host_model host (.clk_in(clk), .rdata_in(rdata), .req_out(req));

    // ==================================================================
    // Helpers
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr_next

    task automatic rnd(output logic [7:0] r);
        seed = lfsr_next(seed);
        r = seed;
    endtask : rnd

    // Poll one completion flag; the first look falls inside the 14-cycle transfer
    task automatic poll(input logic [3:0] code, input int b);
        logic [7:0] d;
        host.rd_reg(code, acl_pkg::OFF_CTRL_ONE, d);
        `CHK(d[b], 1'b0);
        for (int i = 0; i < 20 && d[b] !== 1'b1; i++) host.rd_reg(code, acl_pkg::OFF_CTRL_ONE, d);
        `CHK(d[b], 1'b1);
    endtask : poll

    // Frame launched after one edge, result registered at the next
    task automatic ring_chk(input int p, input logic [15:0] mt, input logic exp);
        @(posedge clk);
        ring <= '{frame: 1'b1, port: 2'(p), match: mt};
        @(posedge clk);
        ring <= '0;
        #1 `CHK(hit, exp);
    endtask : ring_chk

    // ==================================================================
    // Store, fetch and ring check for one port
    task automatic port_pass(input int p);
        logic [7:0]  hi, lo, d;
        logic [3:0]  e;
        logic [13:0] sel;
        logic [15:0] m;
        rnd(hi);
        rnd(lo);
        // Entries 0 and 15 are the boundary cases, others random
        e = (p == 0) ? 4'h0 : (p == 3) ? 4'hF : seed[3:0];
        sel = {hi[5:0], lo};
        host.wr_reg(codes[p], acl_pkg::OFF_BSEL_HI, hi);
        host.wr_reg(codes[p], acl_pkg::OFF_BSEL_LO, lo);
        host.rd_reg(codes[p], acl_pkg::OFF_BSEL_HI, d);
        `CHK(d, {2'b00, hi[5:0]});
        host.rd_reg(codes[p], acl_pkg::OFF_BSEL_LO, d);
        `CHK(d, lo);
        for (int b = 0; b < 14; b++) begin
            rnd(hold[p][b]);
            host.wr_reg(codes[p], 8'(b), hold[p][b]);
        end
        // Only selected bytes land, select bit k covers byte 13-k
        for (int b = 0; b < 14; b++) if (sel[13 - b]) tbl[p][e][b] = hold[p][b];
        host.wr_reg(codes[p], acl_pkg::OFF_CTRL_ONE, {4'h1, e});
        #1 `CHK(busy, 1'b1);
        // A fetch trigger while the store runs must be dropped whole
        host.wr_reg(codes[p], acl_pkg::OFF_CTRL_ONE, {4'h0, ~e});
        poll(codes[p], acl_pkg::STORE_DONE_BIT);
        `CHK(busy, 1'b0);
        host.rd_reg(codes[p], acl_pkg::OFF_CTRL_ONE, d);
        `CHK(d, {4'h7, e});
        // Wipe the holding buffer so only the fetch can refill it
        host.wr_reg(codes[p], acl_pkg::OFF_BSEL_HI, 8'h3F);
        host.wr_reg(codes[p], acl_pkg::OFF_BSEL_LO, 8'hFF);
        for (int b = 0; b < 14; b++) host.wr_reg(codes[p], 8'(b), 8'h00);
        host.wr_reg(codes[p], acl_pkg::OFF_CTRL_ONE, {4'h0, e});
        poll(codes[p], acl_pkg::FETCH_DONE_BIT);
        host.rd_reg(codes[p], acl_pkg::OFF_CTRL_ONE, d);
        `CHK(d, {4'h6, e});
        for (int b = 0; b < 14; b++) begin
            host.rd_reg(codes[p], 8'(b), d);
            `CHK(d, tbl[p][e][b]);
        end
        // Cascade mask, bit 0 forced so a one-bit miss case exists
        rnd(hi);
        rnd(lo);
        m = {hi, lo | 8'h01};
        host.wr_reg(codes[p], acl_pkg::OFF_CASC_HI, m[15:8]);
        host.wr_reg(codes[p], acl_pkg::OFF_CASC_LO, m[7:0]);
        #1 `CHK(casc[p*16 +: 16], m);
        ring_chk(p, m, 1'b1);
        ring_chk(p, m ^ 16'h0001, 1'b0);
        ring_chk(p, 16'hFFFF, 1'b1);
        host.wr_reg(codes[p], acl_pkg::OFF_CTRL_TWO, 8'h01);
        host.rd_reg(codes[p], acl_pkg::OFF_CTRL_TWO, d);
        `CHK(d, 8'h01);
        ring_chk(p, m, 1'b0);
        host.wr_reg(codes[p], acl_pkg::OFF_CTRL_TWO, 8'h00);
    endtask : port_pass

    // ==================================================================
    // Verdict, the single exit of the run
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : complete_run

    // Watchdog: about six times the expected run length
    initial begin
        #400000;
        n_fail++;
        complete_run();
    end

    // Main sequence
    initial begin
        foreach (tbl[p, e, b]) tbl[p][e][b] = 8'h00;
        foreach (hold[p, b]) hold[p][b] = 8'h00;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        host.rd_reg(codes[0], acl_pkg::OFF_CTRL_ONE, rv);
        `CHK(rv, 8'h60);
        host.rd_reg(codes[0], acl_pkg::OFF_CASC_HI, rv);
        `CHK(rv, 8'h00);
        host.rd_reg(codes[0], acl_pkg::OFF_BSEL_HI, rv);
        `CHK(rv, 8'h00);
        // A data write under the read direction must leave the buffer alone
        host.wr_top(acl_pkg::ADDR_IND_CTRL, {acl_pkg::TABLE_SEL_LIST, 1'b1, codes[0]});
        host.wr_top(acl_pkg::ADDR_IND_ADDR, 8'h00);
        host.wr_top(acl_pkg::ADDR_IND_DATA, 8'hA5);
        host.rd_reg(codes[0], 8'h00, rv);
        `CHK(rv, 8'h00);
        host.rd_top(acl_pkg::ADDR_IND_CTRL, rv);
        `CHK(rv, {acl_pkg::TABLE_SEL_LIST, 1'b1, codes[0]});
        for (int p = 0; p < 4; p++) port_pass(p);
        complete_run();
    end
endmodule : tb
